// File: logic/msa_pkg.sv
// Constants and shared arithmetic for slip adaptation and speed/current gain logic.
// Assumes one 50 MHz clock; all parameters arrive from logic on that clock.
package msa_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          SAMPLE_US     = 250;
  localparam int          SAMPLE_CYC    = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam logic [15:0] LOAD_ON_PCT   = 16'h003C;
  localparam logic [15:0] LOAD_OFF_PCT  = 16'h0032;
  localparam int          FREQ_DIV_SH   = 3;
  localparam logic [1:0]  ADAPT_OFF     = 2'h0;
  localparam logic [1:0]  ADAPT_SLOW    = 2'h1;
  localparam logic [1:0]  ADAPT_FAST    = 2'h2;
  localparam int          ADAPT_SLOW_SH = 4;
  localparam int          ADAPT_FAST_SH = 0;
  localparam logic [2:0]  SETUP_USER    = 3'h0;
  localparam logic [2:0]  SETUP_BW      = 3'h1;
  localparam logic [2:0]  SETUP_COMP    = 3'h2;
  localparam logic [2:0]  SETUP_KP_X16  = 3'h3;
  localparam logic [2:0]  SETUP_LOW     = 3'h4;
  localparam logic [2:0]  SETUP_STD     = 3'h5;
  localparam logic [2:0]  SETUP_HIGH    = 3'h6;
  localparam int          KP_X16_SH     = 4;
  localparam logic [15:0] BW_LOW_HZ     = 16'h0005;
  localparam logic [15:0] BW_STD_HZ     = 16'h0019;
  localparam logic [15:0] BW_HIGH_HZ    = 16'h0064;
  localparam logic [15:0] DAMP_UNITY    = 16'h0100;
  localparam logic [15:0] COMP_K        = 16'h0E10;
  localparam int          KP_SH         = 15;
  localparam int          KI_SH         = 8;
  localparam int          GAIN_SH       = 8;
  localparam logic [15:0] CUR_KP_K      = 16'h0040;
  localparam logic [15:0] CUR_KI_K      = 16'h0010;
  localparam logic [15:0] NOM_SPEED_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST      = 16'h0000;

  function automatic logic [15:0] sat_u16(input logic [63:0] v);
    return (|v[63:16]) ? 16'hFFFF : v[15:0];
  endfunction : sat_u16

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction : abs16

  // Kp = 2 * damping * bandwidth * inertia, damping in 8.8
  function automatic logic [15:0] kp_from_bw(input logic [15:0] bw, input logic [15:0] dmp,
                                             input logic [15:0] j);
    return sat_u16((64'(bw) * 64'(dmp) * 64'(j)) >> KP_SH);
  endfunction : kp_from_bw

  function automatic logic [15:0] ki_from_bw(input logic [15:0] bw, input logic [15:0] j);
    return sat_u16((64'(bw) * 64'(bw) * 64'(j)) >> KI_SH);
  endfunction : ki_from_bw

  function automatic logic [15:0] cur_gain(input logic [15:0] x, input logic [15:0] k);
    return sat_u16((64'(x) * 64'(k)) >> GAIN_SH);
  endfunction : cur_gain
endpackage : msa_pkg

// File: logic/msa_slip_gain_top.sv
// Slip adaptation, current loop gain derivation and speed gain set selection.
// Assumes parameter inputs come from host logic on clk_i; slip error from the motor model.
`timescale 1ns/10ps
`default_nettype none
module msa_slip_gain_top #(
  parameter int SAMPLE_CYCLES = msa_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Slip adaptation
  input  wire logic [1:0]         slip_adapt_mode_i,
  input  wire logic [15:0]        motor_nominal_speed_i,
  input  wire logic               nominal_speed_wr_i,
  input  wire logic [15:0]        nominal_frequency_value_i,
  input  wire logic signed [15:0] output_frequency_i,
  input  wire logic signed [15:0] percent_load_i,
  input  wire logic signed [15:0] slip_error_i,
  // Autotune results
  input  wire logic               autotune_done_i,
  input  wire logic [15:0]        stator_resistance_i,
  input  wire logic [15:0]        transient_inductance_i,
  // Speed gain sets and set-up
  input  wire logic [15:0]        speed_prop_gain_set_a_i,
  input  wire logic [15:0]        speed_int_gain_set_a_i,
  input  wire logic [15:0]        speed_diff_gain_set_a_i,
  input  wire logic [15:0]        speed_prop_gain_set_b_i,
  input  wire logic [15:0]        speed_int_gain_set_b_i,
  input  wire logic [15:0]        speed_diff_gain_set_b_i,
  input  wire logic               speed_gain_set_select_i,
  input  wire logic [2:0]         speed_gain_setup_method_i,
  input  wire logic [15:0]        total_inertia_i,
  input  wire logic [15:0]        target_compliance_angle_i,
  input  wire logic [15:0]        target_bandwidth_i,
  input  wire logic [15:0]        target_damping_i,
  // Speed loop
  input  wire logic signed [15:0] speed_ref_i,
  input  wire logic signed [15:0] speed_fb_i,
  // Status and results
  output logic                    slip_adapt_on_o,
  output logic [15:0]             motor_nominal_speed_o,
  output logic [15:0]             current_loop_prop_gain_o,
  output logic [15:0]             current_loop_int_gain_o,
  output logic [15:0]             speed_prop_gain_applied_o,
  output logic [15:0]             speed_int_gain_applied_o,
  output logic [15:0]             speed_diff_gain_applied_o,
  output logic signed [31:0]      torque_ref_o
);
  localparam int CNT_W = $clog2(SAMPLE_CYCLES);

  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic               tick_q, tick_d;
  logic               slip_on_q, slip_on_d;
  logic               restore_q, restore_d;
  logic [15:0]        nom_q, nom_d;
  logic [15:0]        ckp_q, ckp_d, cki_q, cki_d;
  logic [15:0]        akp_q, akp_d, aki_q, aki_d;
  logic [15:0]        kp_q, kp_d, ki_q, ki_d, kd_q, kd_d;
  logic               cond_on, cond_off, adapting, auto_set;
  logic signed [17:0] step, nom_sum;
  logic [15:0]        bw_eq, kp_sel;

  // Sample rate divider
  always_comb
  begin
    tick_d = (cnt_q == CNT_W'(SAMPLE_CYCLES - 1));
    cnt_d  = tick_d ? '0 : cnt_q + CNT_W'(1);
  end

  // Slip adaptation and nominal speed
  always_comb
  begin
    cond_on  = (msa_pkg::abs16(output_frequency_i) >
                (nominal_frequency_value_i >> msa_pkg::FREQ_DIV_SH)) &&
               (msa_pkg::abs16(percent_load_i) > msa_pkg::LOAD_ON_PCT);
    cond_off = (msa_pkg::abs16(percent_load_i) < msa_pkg::LOAD_OFF_PCT);
    slip_on_d = cond_off ? 1'b0 : (cond_on ? 1'b1 : slip_on_q);
    adapting  = slip_on_q && tick_q &&
                (slip_adapt_mode_i == msa_pkg::ADAPT_SLOW ||
                 slip_adapt_mode_i == msa_pkg::ADAPT_FAST);
    // Fast mode is sixteen times slow
    step = (slip_adapt_mode_i == msa_pkg::ADAPT_FAST) ?
           (18'(slip_error_i) >>> msa_pkg::ADAPT_FAST_SH) :
           (18'(slip_error_i) >>> msa_pkg::ADAPT_SLOW_SH);
    nom_sum   = $signed({2'b00, nom_q}) + step;
    restore_d = 1'b0;
    nom_d     = nom_q;
    // User value wins, correction never saved
    if (restore_q || nominal_speed_wr_i)
      nom_d = motor_nominal_speed_i;
    else if (adapting)
      nom_d = nom_sum[17] ? 16'h0000 : (nom_sum[16] ? 16'hFFFF : nom_sum[15:0]);
  end

  // Current and speed gains
  always_comb
  begin
    ckp_d = ckp_q;
    cki_d = cki_q;
    if (autotune_done_i)
    begin
      ckp_d = msa_pkg::cur_gain(transient_inductance_i, msa_pkg::CUR_KP_K);
      cki_d = msa_pkg::cur_gain(stator_resistance_i, msa_pkg::CUR_KI_K);
    end
    // Zero angle would divide by zero; treated as stiffest
    bw_eq = (target_compliance_angle_i == 16'h0000) ? 16'hFFFF :
            16'(32'(msa_pkg::COMP_K) / 32'(target_compliance_angle_i));
    akp_d    = akp_q;
    aki_d    = aki_q;
    auto_set = 1'b1;
    unique case (speed_gain_setup_method_i)
      msa_pkg::SETUP_BW:
      begin
        akp_d = msa_pkg::kp_from_bw(target_bandwidth_i, target_damping_i, total_inertia_i);
        aki_d = msa_pkg::ki_from_bw(target_bandwidth_i, total_inertia_i);
      end
      msa_pkg::SETUP_COMP:
      begin
        akp_d = msa_pkg::kp_from_bw(bw_eq, target_damping_i, total_inertia_i);
        aki_d = msa_pkg::ki_from_bw(bw_eq, total_inertia_i);
      end
      msa_pkg::SETUP_LOW:
      begin
        akp_d = msa_pkg::kp_from_bw(msa_pkg::BW_LOW_HZ, msa_pkg::DAMP_UNITY, total_inertia_i);
        aki_d = msa_pkg::ki_from_bw(msa_pkg::BW_LOW_HZ, total_inertia_i);
      end
      msa_pkg::SETUP_STD:
      begin
        akp_d = msa_pkg::kp_from_bw(msa_pkg::BW_STD_HZ, msa_pkg::DAMP_UNITY, total_inertia_i);
        aki_d = msa_pkg::ki_from_bw(msa_pkg::BW_STD_HZ, total_inertia_i);
      end
      msa_pkg::SETUP_HIGH:
      begin
        akp_d = msa_pkg::kp_from_bw(msa_pkg::BW_HIGH_HZ, msa_pkg::DAMP_UNITY, total_inertia_i);
        aki_d = msa_pkg::ki_from_bw(msa_pkg::BW_HIGH_HZ, total_inertia_i);
      end
      default:
        auto_set = 1'b0;
    endcase
    // Select set; honoured at any time
    if (speed_gain_set_select_i)
    begin
      kp_sel = speed_prop_gain_set_b_i;
      ki_d   = speed_int_gain_set_b_i;
      kd_d   = speed_diff_gain_set_b_i;
    end
    else
    begin
      kp_sel = auto_set ? akp_q : speed_prop_gain_set_a_i;
      ki_d   = auto_set ? aki_q : speed_int_gain_set_a_i;
      kd_d   = speed_diff_gain_set_a_i;
    end
    kp_d = (speed_gain_setup_method_i == msa_pkg::SETUP_KP_X16) ?
           msa_pkg::sat_u16(64'(kp_sel) << msa_pkg::KP_X16_SH) : kp_sel;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q     <= '0;
      tick_q    <= 1'b0;
      slip_on_q <= 1'b0;
      restore_q <= 1'b1;
      nom_q     <= msa_pkg::NOM_SPEED_RST;
      ckp_q     <= msa_pkg::GAIN_RST;
      cki_q     <= msa_pkg::GAIN_RST;
      akp_q     <= msa_pkg::GAIN_RST;
      aki_q     <= msa_pkg::GAIN_RST;
      kp_q      <= msa_pkg::GAIN_RST;
      ki_q      <= msa_pkg::GAIN_RST;
      kd_q      <= msa_pkg::GAIN_RST;
    end
    else
    begin
      cnt_q     <= cnt_d;
      tick_q    <= tick_d;
      slip_on_q <= slip_on_d;
      restore_q <= restore_d;
      nom_q     <= nom_d;
      ckp_q     <= ckp_d;
      cki_q     <= cki_d;
      akp_q     <= akp_d;
      aki_q     <= aki_d;
      kp_q      <= kp_d;
      ki_q      <= ki_d;
      kd_q      <= kd_d;
    end
  end

  msa_speed_pid u_pid (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .tick_i      (tick_q),
    .kp_i        (kp_q),
    .ki_i        (ki_q),
    .kd_i        (kd_q),
    .speed_ref_i (speed_ref_i),
    .speed_fb_i  (speed_fb_i),
    .torque_o    (torque_ref_o)
  );

  assign slip_adapt_on_o           = slip_on_q;
  assign motor_nominal_speed_o     = nom_q;
  assign current_loop_prop_gain_o  = ckp_q;
  assign current_loop_int_gain_o   = cki_q;
  assign speed_prop_gain_applied_o = kp_q;
  assign speed_int_gain_applied_o  = ki_q;
  assign speed_diff_gain_applied_o = kd_q;

  property p_slip_rise;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(slip_on_q) |-> $past(cond_on);
  endproperty
  a_slip_rise: assert property (p_slip_rise) else $error("adaptation on outside window");

  property p_slip_drop;
    @(posedge clk_i) disable iff (!rst_n_i) cond_off |=> !slip_on_q;
  endproperty
  a_slip_drop: assert property (p_slip_drop) else $error("adaptation kept at low load");

  property p_slip_hold;
    @(posedge clk_i) disable iff (!rst_n_i) (!cond_on && !cond_off) |=> $stable(slip_on_q);
  endproperty
  a_slip_hold: assert property (p_slip_hold) else $error("state changed inside band");

  property p_restore;
    @(posedge clk_i) disable iff (!rst_n_i)
    restore_q |=> (nom_q == $past(motor_nominal_speed_i)) && !restore_q;
  endproperty
  a_restore: assert property (p_restore) else $error("saved speed not restored");

  property p_fast_gain;
    @(posedge clk_i) disable iff (!rst_n_i)
    (adapting && !restore_q && !nominal_speed_wr_i && slip_adapt_mode_i == msa_pkg::ADAPT_FAST
     && slip_error_i > -16'sh0080 && slip_error_i < 16'sh0080
     && nom_q > 16'h0080 && nom_q < 16'hFF80)
      |=> (nom_q == $past(nom_q) + 16'($past(slip_error_i)));
  endproperty
  a_fast_gain: assert property (p_fast_gain) else $error("fast adaptation step wrong");

  property p_adapt_idle;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!restore_q && !nominal_speed_wr_i && !slip_on_q) |=> $stable(nom_q);
  endproperty
  a_adapt_idle: assert property (p_adapt_idle) else $error("speed moved while idle");

  property p_cur_gain;
    @(posedge clk_i) disable iff (!rst_n_i)
    autotune_done_i |=> ckp_q == msa_pkg::cur_gain($past(transient_inductance_i),
                                                   msa_pkg::CUR_KP_K);
  endproperty
  a_cur_gain: assert property (p_cur_gain) else $error("current gain not loaded");

  property p_set_b;
    @(posedge clk_i) disable iff (!rst_n_i)
    (speed_gain_set_select_i && speed_gain_setup_method_i == msa_pkg::SETUP_USER)
      |=> (kp_q == $past(speed_prop_gain_set_b_i)) && (kd_q == $past(speed_diff_gain_set_b_i));
  endproperty
  a_set_b: assert property (p_set_b) else $error("set B not applied");

  property p_x16;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!speed_gain_set_select_i && speed_gain_setup_method_i == msa_pkg::SETUP_KP_X16)
      |=> (kp_q == (($past(speed_prop_gain_set_a_i) > 16'h0FFF) ? 16'hFFFF :
                    16'($past(speed_prop_gain_set_a_i) * 16'h0010)));
  endproperty
  a_x16: assert property (p_x16) else $error("kp not multiplied by 16");

  property p_preset;
    @(posedge clk_i) disable iff (!rst_n_i)
    (speed_gain_setup_method_i == msa_pkg::SETUP_STD) |=>
      (akp_q == msa_pkg::kp_from_bw(msa_pkg::BW_STD_HZ, msa_pkg::DAMP_UNITY,
                                    $past(total_inertia_i)));
  endproperty
  a_preset: assert property (p_preset) else $error("preset gain wrong");

  property p_bw;
    @(posedge clk_i) disable iff (!rst_n_i)
    (speed_gain_setup_method_i == msa_pkg::SETUP_BW) |=>
      (aki_q == msa_pkg::ki_from_bw($past(target_bandwidth_i), $past(total_inertia_i)));
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth gain wrong");

  property p_comp;
    @(posedge clk_i) disable iff (!rst_n_i)
    (speed_gain_setup_method_i == msa_pkg::SETUP_COMP) |=> (aki_q == msa_pkg::ki_from_bw(
      $past(bw_eq), $past(total_inertia_i)));
  endproperty
  a_comp: assert property (p_comp) else $error("compliance gain wrong");

  c_slip_on: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(slip_on_q));
  c_autotune: cover property (@(posedge clk_i) disable iff (!rst_n_i) autotune_done_i);
  c_sel_swap: cover property (@(posedge clk_i) disable iff (!rst_n_i)
                              $changed(speed_gain_set_select_i));
endmodule : msa_slip_gain_top
`default_nettype wire

// File: logic/msa_speed_pid.sv
// Speed controller: PI on the error, D on feedback, updated on each sample tick.
// Assumes gains and speeds are stable logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module msa_speed_pid (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               tick_i,
  // Gains, 8.8 fixed point
  input  wire logic [15:0]        kp_i,
  input  wire logic [15:0]        ki_i,
  input  wire logic [15:0]        kd_i,
  // Speeds
  input  wire logic signed [15:0] speed_ref_i,
  input  wire logic signed [15:0] speed_fb_i,
  // Torque reference
  output logic signed [31:0]      torque_o
);
  localparam int GAIN_SH_L = msa_pkg::GAIN_SH;

  logic signed [31:0] integ_q, integ_d;
  logic signed [15:0] fb_prev_q, fb_prev_d;
  logic signed [31:0] torque_q, torque_d;
  logic signed [16:0] err;
  logic signed [16:0] dfb;
  logic signed [47:0] p_term;
  logic signed [47:0] i_sum;
  logic signed [47:0] d_term;
  logic signed [47:0] t_sum;

  function automatic logic signed [31:0] sat32(input logic signed [47:0] v);
    if (v > 48'sh0000_7FFF_FFFF) return 32'sh7FFF_FFFF;
    if (v < -48'sh0000_8000_0000) return -32'sh8000_0000;
    return v[31:0];
  endfunction : sat32

  always_comb
  begin
    err       = 17'(speed_ref_i) - 17'(speed_fb_i);
    dfb       = 17'(speed_fb_i) - 17'(fb_prev_q);
    p_term    = (48'(err) * $signed({1'b0, kp_i})) >>> GAIN_SH_L;
    i_sum     = 48'(integ_q) + ((48'(err) * $signed({1'b0, ki_i})) >>> GAIN_SH_L);
    d_term    = (48'(dfb) * $signed({1'b0, kd_i})) >>> GAIN_SH_L;
    integ_d   = integ_q;
    fb_prev_d = fb_prev_q;
    torque_d  = torque_q;
    if (tick_i)
    begin
      integ_d   = (ki_i == 16'h0000) ? 32'sh0 : sat32(i_sum);
      fb_prev_d = speed_fb_i;
      t_sum     = p_term + 48'(integ_d) - d_term;
      torque_d  = sat32(t_sum);
    end
    else
    begin
      t_sum = 48'sh0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      integ_q   <= 32'sh0;
      fb_prev_q <= 16'sh0;
      torque_q  <= 32'sh0;
    end
    else
    begin
      integ_q   <= integ_d;
      fb_prev_q <= fb_prev_d;
      torque_q  <= torque_d;
    end
  end

  assign torque_o = torque_q;

  property p_int_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick_i && ki_i == 16'h0000) |=> (integ_q == 32'sh0);
  endproperty
  a_int_zero: assert property (p_int_zero) else $error("integral kept with zero gain");

  property p_d_feedback;
    @(posedge clk_i) disable iff (!rst_n_i)
    (tick_i && ki_i == 16'h0000 && speed_ref_i == speed_fb_i && speed_fb_i == fb_prev_q)
      |=> (torque_q == 32'sh0);
  endproperty
  a_d_feedback: assert property (p_d_feedback) else $error("torque without error or motion");
endmodule : msa_speed_pid
`default_nettype wire

// File: verification/msa_motor_model.sv
// Motor and speed feedback stand-in for msa_slip_gain_top.
// Assumes the bench commands it on clk_i; one sampling stage, like a real drive front end.
`timescale 1ns/10ps
`default_nettype none
module msa_motor_model (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Commands from the bench
  input  wire logic signed [15:0] freq_cmd_i,
  input  wire logic signed [15:0] load_cmd_i,
  input  wire logic signed [15:0] slip_cmd_i,
  input  wire logic signed [15:0] fb_cmd_i,
  // Measured quantities
  output logic signed [15:0]      output_frequency_o,
  output logic signed [15:0]      percent_load_o,
  output logic signed [15:0]      slip_error_o,
  output logic signed [15:0]      speed_fb_o
);
  // Sampled once per clock, so the block sees each change one edge late
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      output_frequency_o <= 16'sh0000;
      percent_load_o     <= 16'sh0000;
      slip_error_o       <= 16'sh0000;
      speed_fb_o         <= 16'sh0000;
    end
    else
    begin
      output_frequency_o <= freq_cmd_i;
      percent_load_o     <= load_cmd_i;
      slip_error_o       <= slip_cmd_i;
      speed_fb_o         <= fb_cmd_i;
    end
  end
endmodule : msa_motor_model
`default_nettype wire

// File: verification/msa_slip_gain_top_tb.sv
// Bench for msa_slip_gain_top: gain sets, set-up methods, autotune, slip adaptation.
// Assumes msa_motor_model on the far side; expectations queue and a negedge monitor.
`timescale 1ns/10ps
`default_nettype none
`define CHK(s, v, l) q.push_back('{s, 32'(v), cyc + 1 + (l)})
module msa_slip_gain_top_tb;
  typedef struct {int s; logic [31:0] v; int at;} msa_exp_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic nominal_speed_wr_i = 1'b0;
  logic autotune_done_i = 1'b0;
  logic speed_gain_set_select_i = 1'b0;
  logic [1:0] slip_adapt_mode_i = 2'h1;
  logic [2:0] speed_gain_setup_method_i = 3'h0;
  logic [15:0] motor_nominal_speed_i = 16'h1000;
  logic [15:0] nominal_frequency_value_i = 16'h0190;
  logic [15:0] stator_resistance_i = 16'h0000;
  logic [15:0] transient_inductance_i = 16'h0000;
  logic [15:0] speed_prop_gain_set_a_i, speed_int_gain_set_a_i, speed_diff_gain_set_a_i;
  logic [15:0] speed_prop_gain_set_b_i, speed_int_gain_set_b_i, speed_diff_gain_set_b_i;
  logic [15:0] total_inertia_i = 16'h0200;
  logic [15:0] target_compliance_angle_i = 16'h00B4;
  logic [15:0] target_bandwidth_i = 16'h000A;
  logic [15:0] target_damping_i = 16'h0180;
  logic signed [15:0] speed_ref_i = 16'sh0064;
  logic signed [15:0] output_frequency_i, percent_load_i, slip_error_i, speed_fb_i;
  logic signed [15:0] fq = 16'sh0000, ld = 16'sh0000, sl = 16'sh0000, fb = 16'sh0028;
  logic slip_adapt_on_o;
  logic [15:0] motor_nominal_speed_o, current_loop_prop_gain_o, current_loop_int_gain_o;
  logic [15:0] speed_prop_gain_applied_o, speed_int_gain_applied_o, speed_diff_gain_applied_o;
  logic signed [31:0] torque_ref_o;
  logic [31:0] lf = 32'h00017E46;
  msa_exp_t q[$];
  int cyc = 0;
  int errors = 0;
  int n_checks = 0;
  string nm [8] = '{"adapt_on", "speed", "cur_kp", "cur_ki", "kp", "ki", "kd", "torque"};

  msa_slip_gain_top #(.SAMPLE_CYCLES(8)) dut (.*);
  msa_motor_model mm (.clk_i, .rst_n_i, .freq_cmd_i(fq), .load_cmd_i(ld), .slip_cmd_i(sl),
    .fb_cmd_i(fb), .output_frequency_o(output_frequency_i), .percent_load_o(percent_load_i),
    .slip_error_o(slip_error_i), .speed_fb_o(speed_fb_i));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  function automatic logic [15:0] sat(input logic [63:0] v);
    return (|v[63:16]) ? 16'hFFFF : v[15:0];
  endfunction : sat

  function automatic logic [31:0] obs(input int s);
    case (s)
      0: return {31'h0, slip_adapt_on_o};
      1: return {16'h0, motor_nominal_speed_o};
      2: return {16'h0, current_loop_prop_gain_o};
      3: return {16'h0, current_loop_int_gain_o};
      4: return {16'h0, speed_prop_gain_applied_o};
      5: return {16'h0, speed_int_gain_applied_o};
      6: return {16'h0, speed_diff_gain_applied_o};
      default: return torque_ref_o;
    endcase
  endfunction : obs

  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cy

  task automatic chk_set(input logic s, input int l);
    `CHK(4, s ? speed_prop_gain_set_b_i : speed_prop_gain_set_a_i, l);
    `CHK(5, s ? speed_int_gain_set_b_i : speed_int_gain_set_a_i, l);
    `CHK(6, s ? speed_diff_gain_set_b_i : speed_diff_gain_set_a_i, l);
  endtask : chk_set

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial
    forever #10 clk_i = ~clk_i;

  always @(posedge clk_i)
    cyc <= cyc + 1;

  // Oldest note first; results are settled by the falling edge
  always @(negedge clk_i)
  begin
    while (q.size() > 0 && q[0].at <= cyc)
    begin
      n_checks++;
      if (obs(q[0].s) !== q[0].v)
      begin
        errors++;
        $display("wrong value %s expected %h seen %h", nm[q[0].s], q[0].v, obs(q[0].s));
      end
      void'(q.pop_front());
    end
  end

  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  initial
  begin : main
    logic [15:0] s0;
    logic [15:0] b;
    logic [15:0] d;
    lf = nxt(lf);
    speed_prop_gain_set_a_i = lf[15:0];
    speed_prop_gain_set_b_i = lf[31:16];
    lf = nxt(lf);
    speed_int_gain_set_a_i = lf[15:0];
    speed_int_gain_set_b_i = lf[31:16];
    lf = nxt(lf);
    speed_diff_gain_set_a_i = lf[15:0];
    speed_diff_gain_set_b_i = lf[31:16];
    cy(16);
    rst_n_i <= 1'b1;
    `CHK(1, motor_nominal_speed_i, 1);
    cy(3);
    // Selector flipped both ways, drive state irrelevant
    for (int s = 1; s >= 0; s--)
    begin
      speed_gain_set_select_i <= s[0];
      chk_set(s[0], 1);
      cy(3);
    end
    for (int m = 1; m < 7; m++)
    begin
      speed_gain_setup_method_i <= m[2:0];
      b = (m == 1) ? target_bandwidth_i : (m == 2) ? msa_pkg::COMP_K / target_compliance_angle_i
        : (m == 4) ? 16'h0005 : (m == 5) ? 16'h0019 : 16'h0064;
      d = (m < 3) ? target_damping_i : msa_pkg::DAMP_UNITY;
      if (m == 3)
      begin
        `CHK(4, sat(64'(speed_prop_gain_set_a_i) << 4), 2);
        `CHK(5, speed_int_gain_set_a_i, 2);
      end
      else
      begin
        `CHK(4, sat((64'(b) * d * total_inertia_i) >> 15), 2);
        `CHK(5, sat((64'(b) * b * total_inertia_i) >> 8), 2);
      end
      `CHK(6, speed_diff_gain_set_a_i, 2);
      cy(4);
    end
    speed_gain_setup_method_i <= 3'h0;
    lf = nxt(lf);
    transient_inductance_i <= lf[15:0];
    stator_resistance_i <= lf[31:16];
    autotune_done_i <= 1'b1;
    `CHK(2, sat((64'(lf[15:0]) * 16'h0040) >> 8), 1);
    `CHK(3, sat((64'(lf[31:16]) * 16'h0010) >> 8), 1);
    cy(1);
    autotune_done_i <= 1'b0;
    transient_inductance_i <= ~lf[15:0];
    `CHK(2, sat((64'(lf[15:0]) * 16'h0040) >> 8), 2);
    cy(3);
    // Frequency boundary first, then load walks through the band
    for (int i = 0; i < 7; i++)
    begin
      fq <= (i == 0) ? 16'sh0032 : 16'shFFCD;
      ld <= (i == 0 || i == 1) ? 16'sh0046 : (i == 2) ? 16'sh0037 : (i == 3) ? 16'sh0032
        : (i == 4) ? 16'shFFCF : (i == 5) ? 16'sh003C : 16'shFFC3;
      `CHK(0, 7'h4E >> i & 7'h01, 2);
      cy(3);
    end
    motor_nominal_speed_i <= 16'h2000;
    nominal_speed_wr_i <= 1'b1;
    `CHK(1, 16'h2000, 1);
    cy(1);
    nominal_speed_wr_i <= 1'b0;
    // Mode 3 must act as off
    for (int k = 0; k < 4; k++)
    begin
      slip_adapt_mode_i <= k[1:0];
      sl <= (k == 2) ? 16'shFFE0 : 16'sh0010;
      cy(4);
      @(negedge clk_i);
      s0 = motor_nominal_speed_o + ((k == 1) ? 16'h0001 : (k == 2) ? 16'hFFE0 : 16'h0000);
      `CHK(1, s0, 7);
      cy(10);
    end
    rst_n_i <= 1'b0;
    cy(2);
    rst_n_i <= 1'b1;
    `CHK(1, 16'h2000, 1);
    speed_prop_gain_set_b_i <= 16'h0100;
    speed_int_gain_set_b_i <= 16'h0000;
    speed_diff_gain_set_b_i <= 16'h0200;
    speed_gain_set_select_i <= 1'b1;
    // First tick sees the feedback jump out of reset
    cy(12);
    `CHK(7, 32'hFFFFFFEC, 0);
    cy(12);
    `CHK(7, 32'h0000003C, 0);
    cy(16);
    `CHK(7, 32'h0000003C, 0);
    speed_ref_i <= 16'sh00A0;
    cy(12);
    `CHK(7, 32'h00000078, 0);
    speed_ref_i <= 16'sh0028;
    cy(12);
    `CHK(7, 32'h00000000, 0);
    cy(4);
    if (q.size() != 0)
      errors++;
    close_out();
  end
endmodule : msa_slip_gain_top_tb
`default_nettype wire
